// File: hw/status_alu.sv
`timescale 1ns/1ns
`default_nettype none
`include "status_cfg.svh"

module status_alu
  import status_pkg::*;
(
  input  wire alu_op_t      op,
  input  wire logic [7:0]   a,
  input  wire logic [7:0]   b,
  input  wire logic         c_in,
  output logic [7:0]        result,
  output flag_update_t      upd
);

  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] b_eff;
  logic       cin_eff;

  always_comb begin
    result  = 8'h00;
    upd     = '0;
    // subtraction is add of the complement plus one
    b_eff   = (op == OP_SUB) ? ~b : b;
    cin_eff = (op == OP_SUB);
    sum     = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
    low     = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    case (op)
      OP_ADD, OP_SUB: begin
        result          = sum[7:0];
        upd.z_upd       = 1'b1;
        upd.dc_upd      = 1'b1;
        upd.c_upd       = 1'b1;
        upd.flags.dc    = low[4];
        upd.flags.c     = sum[8];
      end
      OP_AND: begin
        result    = a & b;
        upd.z_upd = 1'b1;
      end
      OP_OR: begin
        result    = a | b;
        upd.z_upd = 1'b1;
      end
      OP_XOR: begin
        result    = a ^ b;
        upd.z_upd = 1'b1;
      end
      OP_ZERO_RESULT: begin
        result    = 8'h00;
        upd.z_upd = 1'b1;
      end
      OP_ROT_LEFT: begin
        result      = {a[6:0], c_in};
        upd.c_upd   = 1'b1;
        upd.flags.c = a[7];
      end
      OP_ROT_RIGHT: begin
        result      = {c_in, a[7:1]};
        upd.c_upd   = 1'b1;
        upd.flags.c = a[0];
      end
      OP_PASS: begin
        result = a;
      end
      default: begin
        result = 8'h00;
      end
    endcase
    upd.flags.z = (result == 8'h00);
  end

endmodule : status_alu
`default_nettype wire

// File: hw/status_cfg.svh
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH

`define STAT_ADDR_LO      8'h03
`define STAT_ADDR_HI      8'h83
`define BANK_SPAN         9'd128

`define BIT_IND_BANK      7
`define BIT_DIR_UPPER     6
`define BIT_DIR_LOWER     5
`define BIT_WDT_EXP       4
`define BIT_PWR_DOWN      3
`define BIT_ZERO          2
`define BIT_NIBBLE        1
`define BIT_CARRY         0

`define RST_DIR_LOWER     1'b0
`define RST_WDT_EXP       1'b1
`define RST_PWR_DOWN      1'b1

`endif

// File: hw/status_pkg.sv
package status_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADD,
    OP_SUB,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_ZERO_RESULT,
    OP_ROT_LEFT,
    OP_ROT_RIGHT,
    OP_PASS
  } alu_op_t;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } alu_flags_t;

  typedef struct packed {
    logic       z_upd;
    logic       dc_upd;
    logic       c_upd;
    alu_flags_t flags;
  } flag_update_t;

  typedef struct packed {
    logic       ind_bank;
    logic       dir_upper;
    logic       dir_lower;
    logic       wdt_exp;
    logic       pwr_down;
    alu_flags_t arith;
  } status_t;

endpackage : status_pkg

// File: hw/status_reg.sv
// How it works
// - The status byte is a legal destination of any instruction, written like any data register.
// - When the instruction updates zero, nibble carry or carry, the written data for all three of those bits is dropped.
// - Data writes never change the watchdog expiry or power-down flags.
// - Zeroing the status byte clears bits 7:5 and sets zero, keeping the other flags.
// - In subtraction carry and nibble carry are inverted borrow outs.
// - The byte is mapped at data address 03h and mirrored at 83h.
// - The lower bank bit picks bank 0 (00h-7Fh) or bank 1 (80h-FFh), 128 bytes each.
// - Watchdog expiry flag sets on power-up, watchdog kick and sleep, clears on a time-out.
// - Power-down flag sets on power-up or watchdog kick, clears on sleep.
// - Zero flag follows whether the result is zero, for ops that affect it.
// - Nibble carry is the carry from bit 3 into bit 4 on add and subtract.
// - Carry is the carry out of bit 7 on add and subtract.
// - Subtraction adds the two's complement, so carry is 1 when no borrow happened.
// - Rotates load carry with the bit shifted out.
`timescale 1ns/1ns
`default_nettype none
`include "status_cfg.svh"

module status_reg
  import status_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        EXEC,
  input  wire alu_op_t     ALU_OP,
  input  wire logic [7:0]  OPERAND_A,
  input  wire logic [7:0]  OPERAND_B,
  input  wire logic        DEST_WRITE,
  input  wire logic [6:0]  DEST_OFFSET,
  input  wire logic        WATCHDOG_KICK_OP,
  input  wire logic        SLEEP_OP,
  input  wire logic        WATCHDOG_TIMEOUT,
  input  wire logic [7:0]  RD_OFFSET,
  output logic [7:0]       RESULT,
  output logic [8:0]       DEST_ADDR,
  output logic             DEST_IS_STATUS,
  output logic [7:0]       RD_DATA,
  output logic [7:0]       STATUS_OUT,
  output logic             DIRECT_BANK_LOWER
);

  status_t      stat_r;
  status_t      stat_nxt;
  logic [7:0]   rd_data_r;
  logic [7:0]   rd_data_nxt;
  logic [7:0]   alu_result;
  flag_update_t upd;
  logic         wr_status;
  logic [7:0]   wdata;

  // decodes either mirror of the status location
  function automatic logic is_status(input logic [7:0] addr);
    is_status = (addr == `STAT_ADDR_LO) || (addr == `STAT_ADDR_HI);
  endfunction : is_status

  status_alu u_alu (
    .op     (ALU_OP),
    .a      (OPERAND_A),
    .b      (OPERAND_B),
    .c_in   (stat_r.arith.c),
    .result (alu_result),
    .upd    (upd)
  );

  // bank bit selects 128-byte half; bits 7:6 are not decoded
  assign DEST_ADDR         = {1'b0, stat_r.dir_lower, DEST_OFFSET};
  assign DEST_IS_STATUS    = is_status(DEST_ADDR[7:0]);
  assign wr_status         = EXEC && DEST_WRITE && DEST_IS_STATUS;
  assign wdata             = alu_result;
  assign RESULT            = alu_result;
  assign STATUS_OUT        = stat_r;
  assign DIRECT_BANK_LOWER = stat_r.dir_lower;
  assign RD_DATA           = rd_data_r;

  always_comb begin
    stat_nxt = stat_r;
    if (wr_status) begin
      stat_nxt.ind_bank  = wdata[`BIT_IND_BANK];
      stat_nxt.dir_upper = wdata[`BIT_DIR_UPPER];
      stat_nxt.dir_lower = wdata[`BIT_DIR_LOWER];
      // expiry and power-down stay as they are on data writes
      // any flag update blocks the data for all three arithmetic bits
      if (!(upd.z_upd || upd.dc_upd || upd.c_upd)) begin
        stat_nxt.arith.z  = wdata[`BIT_ZERO];
        stat_nxt.arith.dc = wdata[`BIT_NIBBLE];
        stat_nxt.arith.c  = wdata[`BIT_CARRY];
      end
    end
    // alu flags applied after the data write so they win
    if (EXEC) begin
      if (upd.z_upd)
        stat_nxt.arith.z = upd.flags.z;
      if (upd.dc_upd)
        stat_nxt.arith.dc = upd.flags.dc;
      if (upd.c_upd)
        stat_nxt.arith.c = upd.flags.c;
    end
    // a time-out in the same cycle as a kick or sleep wins: the event is not lost
    if (EXEC && (WATCHDOG_KICK_OP || SLEEP_OP))
      stat_nxt.wdt_exp = 1'b1;
    if (WATCHDOG_TIMEOUT)
      stat_nxt.wdt_exp = 1'b0;
    if (EXEC && WATCHDOG_KICK_OP)
      stat_nxt.pwr_down = 1'b1;
    else if (EXEC && SLEEP_OP)
      stat_nxt.pwr_down = 1'b0;
  end

  // registered read port, mirrors decode the same byte
  always_comb begin
    rd_data_nxt = 8'h00;
    if (is_status(RD_OFFSET))
      rd_data_nxt = stat_nxt;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      stat_r           <= '0;
      stat_r.dir_lower <= `RST_DIR_LOWER;
      stat_r.wdt_exp   <= `RST_WDT_EXP;
      stat_r.pwr_down  <= `RST_PWR_DOWN;
      rd_data_r        <= 8'h00;
    end else begin
      stat_r    <= stat_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

endmodule : status_reg
`default_nettype wire

// File: tb/core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model
  import status_pkg::*;
(
  input  wire logic   clk,
  output logic        exec,
  output var alu_op_t op,
  output logic [7:0]  a,
  output logic [7:0]  b,
  output logic        dw,
  output logic [6:0]  off,
  output logic        kick,
  output logic        sleep,
  output logic        tmo
);
  initial begin
    {exec, a, b, dw, off, kick, sleep, tmo} = '0;
    op = OP_NONE;
  end
  // ctl = {dest write, kick, sleep, time-out}; dest write targets 03h and masks a to 3Fh, time-out drops exec
  task automatic issue(input alu_op_t o, input logic [7:0] va, vb, input logic [3:0] ctl);
    @(posedge clk);
    #1;
    {dw, kick, sleep, tmo} = ctl;
    exec = !ctl[0];
    op = o;
    a = ctl[3] ? (va & 8'h3f) : va;
    b = vb;
    off = ctl[3] ? 7'h03 : 7'h10;
    @(posedge clk);
    #1;
    {exec, dw, kick, sleep, tmo} = '0;
  endtask : issue
endmodule : core_model
`default_nettype wire

// File: tb/status_reg_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module status_reg_monitor
  import status_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       EXEC,
  input wire alu_op_t    ALU_OP,
  input wire logic [7:0] OPERAND_A,
  input wire logic [7:0] OPERAND_B,
  input wire logic       DEST_WRITE,
  input wire logic [6:0] DEST_OFFSET,
  input wire logic       WATCHDOG_KICK_OP,
  input wire logic       SLEEP_OP,
  input wire logic       WATCHDOG_TIMEOUT,
  input wire logic [7:0] RD_OFFSET,
  input wire logic       DEST_IS_STATUS,
  input wire logic [7:0] RD_DATA,
  input wire logic [7:0] STATUS_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic       sub;
  logic [8:0] sum;
  logic [4:0] nib;
  logic       evt;
  assign sub = (ALU_OP == OP_SUB);
  assign sum = {1'b0, OPERAND_A} + {1'b0, OPERAND_B ^ {8{sub}}} + {8'h00, sub};
  assign nib = {1'b0, OPERAND_A[3:0]} + {1'b0, OPERAND_B[3:0] ^ {4{sub}}} + {4'h0, sub};
  assign evt = WATCHDOG_TIMEOUT | (EXEC & (WATCHDOG_KICK_OP | SLEEP_OP));
  sequence clear_cmd;
    EXEC && ALU_OP == OP_ZERO_RESULT && DEST_WRITE && DEST_IS_STATUS && !evt;
  endsequence
  AST_TIMEOUT: assert property (WATCHDOG_TIMEOUT |=> !STATUS_OUT[4])
    else $error("expiry flag kept");
  AST_KICK: assert property (EXEC && WATCHDOG_KICK_OP && !WATCHDOG_TIMEOUT |=> STATUS_OUT[4:3] == 2'b11)
    else $error("kick flags");
  AST_SLEEP: assert property (EXEC && SLEEP_OP && !WATCHDOG_KICK_OP && !WATCHDOG_TIMEOUT
    |=> STATUS_OUT[4:3] == 2'b10) else $error("sleep flags");
  AST_CLEAR: assert property (clear_cmd
    |=> STATUS_OUT[7:5] == 3'b000 && STATUS_OUT[2] && STATUS_OUT[1:0] == $past(STATUS_OUT[1:0]))
    else $error("clear result");
  AST_ARITH: assert property (EXEC && (ALU_OP == OP_ADD || sub)
    |=> STATUS_OUT[2:0] == {$past(sum[7:0]) == 8'h00, $past(nib[4]), $past(sum[8])}) else $error("arith flags");
  AST_HOLD: assert property (!EXEC && !WATCHDOG_TIMEOUT |=> $stable(STATUS_OUT))
    else $error("status moved");
  AST_NOWRITE: assert property (EXEC && DEST_WRITE && DEST_IS_STATUS && !evt
    |=> STATUS_OUT[4:3] == $past(STATUS_OUT[4:3])) else $error("reset-cause flags written");
  AST_DECODE: assert property (EXEC && DEST_WRITE && DEST_OFFSET == 7'h03 |-> DEST_IS_STATUS)
    else $error("decode");
  AST_READ: assert property (RD_OFFSET == 8'h03 || RD_OFFSET == 8'h83 |=> RD_DATA == STATUS_OUT)
    else $error("read data");
endmodule : status_reg_monitor
bind status_reg status_reg_monitor u_mon (.CLK, .RSTN, .EXEC, .ALU_OP, .OPERAND_A, .OPERAND_B, .DEST_WRITE,
  .DEST_OFFSET, .WATCHDOG_KICK_OP, .SLEEP_OP, .WATCHDOG_TIMEOUT, .RD_OFFSET, .DEST_IS_STATUS, .RD_DATA, .STATUS_OUT);
`default_nettype wire

// File: tb/tb_alu_status_register.sv
`timescale 1ns/1ns
`default_nettype none
module tb_alu_status_register
  import status_pkg::*;
;
  typedef struct packed {alu_op_t op; logic [7:0] a; logic [7:0] b; logic [7:0] r; logic [2:0] f;} row_t;
  logic       clk, rstn, exec, dw, kick, sleep, tmo, bank, dis;
  alu_op_t    op;
  logic [7:0] a, b, rd, st, res, ro;
  logic [8:0] daddr;
  logic [6:0] off;
  int         num_errors, check_count;
  // result is looked at after the update, so rotates see the new carry in
  row_t rows[10] = '{'{OP_ADD, 8'h0f, 8'h01, 8'h10, 3'b010}, '{OP_ADD, 8'hff, 8'h01, 8'h00, 3'b111},
    '{OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111}, '{OP_SUB, 8'h03, 8'h05, 8'hfe, 3'b000},
    '{OP_AND, 8'hf0, 8'h0f, 8'h00, 3'b100}, '{OP_ROT_LEFT, 8'h80, 8'h00, 8'h01, 3'b101},
    '{OP_ROT_RIGHT, 8'h02, 8'h00, 8'h01, 3'b100}, '{OP_OR, 8'h01, 8'h00, 8'h01, 3'b000},
    '{OP_XOR, 8'h5a, 8'h5a, 8'h00, 3'b100}, '{OP_PASS, 8'h00, 8'h00, 8'h00, 3'b100}};
  always #20 clk = ~clk;
  core_model core (.clk, .exec, .op, .a, .b, .dw, .off, .kick, .sleep, .tmo);
  status_reg DUT (.CLK(clk), .RSTN(rstn), .EXEC(exec), .ALU_OP(op), .OPERAND_A(a), .OPERAND_B(b),
    .DEST_WRITE(dw), .DEST_OFFSET(off), .WATCHDOG_KICK_OP(kick), .SLEEP_OP(sleep), .WATCHDOG_TIMEOUT(tmo),
    .RD_OFFSET(ro), .RESULT(res), .DEST_ADDR(daddr), .DEST_IS_STATUS(dis), .RD_DATA(rd), .STATUS_OUT(st),
    .DIRECT_BANK_LOWER(bank));
  task automatic chk(input string nm, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_addr(input string nm, input logic [8:0] exp, got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_addr
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // hang guard
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    clk = 0;
    rstn = 0;
    ro = 8'h83;
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    chk("reset", 8'h18, st & 8'hf8);
    foreach (rows[i]) begin
      core.issue(rows[i].op, rows[i].a, rows[i].b, 4'h0);
      chk("flags", {5'h00, rows[i].f}, {5'h00, st[2:0]});
      chk("result", rows[i].r, res);
    end
    chk_addr("dest_other", 9'h010, daddr);
    chk("is_status_other", 8'h00, {7'h00, dis});
    core.issue(OP_NONE, 8'h00, 8'h00, 4'h2);
    chk("sleep", 8'h14, st);
    core.issue(OP_PASS, 8'h3f, 8'h00, 4'h8);
    chk("move", 8'h37, st);
    chk("bank", 8'h01, {7'h00, bank});
    chk("move_result", 8'h3f, res);
    chk_addr("dest_mirror", 9'h083, daddr);
    chk("is_status_mirror", 8'h01, {7'h00, dis});
    chk("read", 8'h37, rd);
    ro = 8'h03;
    @(posedge clk);
    #1;
    chk("read_lo", 8'h37, rd);
    ro = 8'h10;
    @(posedge clk);
    #1;
    chk("read_other", 8'h00, rd);
    ro = 8'h83;
    core.issue(OP_ADD, 8'h00, 8'h00, 4'h8);
    chk("add_dest", 8'h14, st);
    chk_addr("dest_lo", 9'h003, daddr);
    core.issue(OP_PASS, 8'h23, 8'h00, 4'h8);
    chk("move_flags", 8'h33, st);
    core.issue(OP_ZERO_RESULT, 8'h00, 8'h00, 4'h8);
    chk("clear", 8'h17, st);
    core.issue(OP_OR, 8'h06, 8'h00, 4'h8);
    chk("or_dest", 8'h13, st);
    core.issue(OP_NONE, 8'h00, 8'h00, 4'h1);
    chk("timeout", 8'h03, st);
    core.issue(OP_NONE, 8'h00, 8'h00, 4'h6);
    chk("kick_sleep", 8'h1b, st);
    core.issue(OP_NONE, 8'h00, 8'h00, 4'h2);
    chk("sleep_again", 8'h13, st);
    core.issue(OP_NONE, 8'h00, 8'h00, 4'h4);
    chk("kick", 8'h1b, st);
    conclude();
  end
endmodule : tb_alu_status_register
`default_nettype wire
